// >>> sdc_conv_ctrl.sv
`default_nettype none
module sdc_conv_ctrl (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic mod_bit,
	output logic mod_enable,
	output logic low_power,
	output logic [2:0] mux_channel,
	output logic noninv_from_mux,
	output logic inv_from_mux,
	output logic irq
);

	localparam int NCH = sdc_pkg::NCH;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic start_q, start_d, lp_q, lp_d;
	logic [3:0] ref_div_q, ref_div_d;
	logic [2:0] osr_q [NCH];
	logic [2:0] osr_d [NCH];
	logic [NCH-1:0] se_q, se_d, neg_q, neg_d, scan_q, scan_d;
	logic [sdc_pkg::OUT_W-1:0] data_q [NCH];
	logic [sdc_pkg::OUT_W-1:0] data_d [NCH];
	logic [NCH-1:0] int_stat_q, int_stat_d, int_en_q, int_en_d;
	logic wr_pend_q, wr_pend_d;
	logic [7:0] waddr_q, waddr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic take;

	logic [3:0] ref_cnt_q, ref_cnt_d;
	logic [2:0] lp_cnt_q, lp_cnt_d;
	logic [1:0] os_cnt_q, os_cnt_d;
	logic [10:0] dec_cnt_q, dec_cnt_d;
	logic ref_tick, settle_tick, os_tick, dec_tick;
	logic [10:0] osr_last;

	sdc_pkg::sdc_state_t st_q, st_d;
	logic [2:0] ch_q, ch_d, nxt_ch;
	logic [9:0] cnt_q, cnt_d;
	logic [1:0] outs_q, outs_d;
	logic pub_q, pub_d;
	logic [2:0] pub_ch_q, pub_ch_d;
	logic filt_clr;
	logic publish;
	logic route_p_q, route_p_d, route_n_q, route_n_d;
	logic flt_valid;
	logic [sdc_pkg::OUT_W-1:0] flt_data;
	logic [3:0] flt_shift;
	logic [2:0] cur_osr;

	// Next enabled channel after the current one, wrapping
	function automatic logic [2:0] next_scan(input logic [2:0] cur, input logic [NCH-1:0] en);
		logic [2:0] res;
		logic found;
		logic [2:0] idx;
		res = cur;
		found = 1'b0;
		for (int k = 1; k <= NCH; k++) begin
			idx = 3'((int'(cur) + k) % NCH);
			if (!found && en[idx]) begin
				res = idx;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	// ****************************************************************
	// AHB-Lite slave and register file
	// ****************************************************************
	assign take = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign publish = (st_q == sdc_pkg::SDC_CONV) && flt_valid && (outs_q == sdc_pkg::SETTLE_OUT_LAST);

	// Register next values, read mux and event capture
	always_comb begin
		start_d = start_q;
		lp_d = lp_q;
		ref_div_d = ref_div_q;
		osr_d = osr_q;
		se_d = se_q;
		neg_d = neg_q;
		scan_d = scan_q;
		data_d = data_q;
		int_en_d = int_en_q;
		int_stat_d = int_stat_q;
		wr_pend_d = take && hwrite;
		waddr_d = take ? haddr[7:0] : waddr_q;
		hrdata_d = hrdata_q;
		if (wr_pend_q) begin
			if (waddr_q == sdc_pkg::CTRL_OFS) begin
				start_d = hwdata[sdc_pkg::CTRL_START_BIT];
				lp_d = hwdata[sdc_pkg::CTRL_LP_BIT];
				ref_div_d = hwdata[sdc_pkg::CTRL_DIV_LSB +: 4];
			end
			if (waddr_q == sdc_pkg::INT_EN_OFS) begin
				int_en_d = hwdata[NCH-1:0];
			end
			if (waddr_q == sdc_pkg::INT_CLR_OFS) begin
				int_stat_d = int_stat_q & ~hwdata[NCH-1:0];
			end
			if (waddr_q[7:5] == sdc_pkg::CHCFG_PAGE && int'(waddr_q[4:2]) < NCH) begin
				osr_d[waddr_q[4:2]] = hwdata[sdc_pkg::CFG_OSR_LSB +: 3];
				se_d[waddr_q[4:2]] = hwdata[sdc_pkg::CFG_SE_BIT];
				neg_d[waddr_q[4:2]] = hwdata[sdc_pkg::CFG_NEG_BIT];
				scan_d[waddr_q[4:2]] = hwdata[sdc_pkg::CFG_SCAN_BIT];
			end
		end
		// sample stored first, flag next cycle
		if (publish) begin
			data_d[ch_q] = flt_data;
		end
		if (pub_q) begin
			int_stat_d[pub_ch_q] = 1'b1;
		end
		if (take && !hwrite) begin
			hrdata_d = 32'h0000_0000;
			if (haddr[7:0] == sdc_pkg::CTRL_OFS) begin
				hrdata_d[sdc_pkg::CTRL_START_BIT] = start_q;
				hrdata_d[sdc_pkg::CTRL_LP_BIT] = lp_q;
				hrdata_d[sdc_pkg::CTRL_DIV_LSB +: 4] = ref_div_q;
			end
			if (haddr[7:0] == sdc_pkg::STATUS_OFS) begin
				hrdata_d[1:0] = st_q;
				hrdata_d[4:2] = ch_q;
			end
			if (haddr[7:0] == sdc_pkg::INT_STAT_OFS) begin
				hrdata_d[NCH-1:0] = int_stat_q;
			end
			if (haddr[7:0] == sdc_pkg::INT_EN_OFS) begin
				hrdata_d[NCH-1:0] = int_en_q;
			end
			if (haddr[7:5] == sdc_pkg::CHCFG_PAGE && int'(haddr[4:2]) < NCH) begin
				hrdata_d[sdc_pkg::CFG_OSR_LSB +: 3] = osr_q[haddr[4:2]];
				hrdata_d[sdc_pkg::CFG_SE_BIT] = se_q[haddr[4:2]];
				hrdata_d[sdc_pkg::CFG_NEG_BIT] = neg_q[haddr[4:2]];
				hrdata_d[sdc_pkg::CFG_SCAN_BIT] = scan_q[haddr[4:2]];
			end
			if (haddr[7:5] == sdc_pkg::DATA_PAGE && int'(haddr[4:2]) < NCH) begin
				hrdata_d[sdc_pkg::OUT_W-1:0] = data_q[haddr[4:2]];
			end
		end
	end

	// Register file flops
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			start_q <= 1'b0;
			lp_q <= 1'b0;
			ref_div_q <= sdc_pkg::REF_DIV_RST;
			osr_q <= '{default: sdc_pkg::CFG_OSR_RST};
			se_q <= '0;
			neg_q <= '0;
			scan_q <= '0;
			data_q <= '{default: '0};
			int_en_q <= '0;
			int_stat_q <= '0;
			wr_pend_q <= 1'b0;
			waddr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			start_q <= start_d;
			lp_q <= lp_d;
			ref_div_q <= ref_div_d;
			osr_q <= osr_d;
			se_q <= se_d;
			neg_q <= neg_d;
			scan_q <= scan_d;
			data_q <= data_d;
			int_en_q <= int_en_d;
			int_stat_q <= int_stat_d;
			wr_pend_q <= wr_pend_d;
			waddr_q <= waddr_d;
			hrdata_q <= hrdata_d;
		end
	end

	// Level interrupt while an enabled status bit is set
	assign irq = |(int_stat_q & int_en_q);

	// ****************************************************************
	// Clock dividers
	// ****************************************************************
	assign cur_osr = (osr_q[ch_q] > 3'(sdc_pkg::OSR_SEL_MAX)) ? 3'(sdc_pkg::OSR_SEL_MAX) : osr_q[ch_q];
	assign osr_last = 11'((32'd64 << cur_osr) - 1);
	assign flt_shift = 4'(3 * (sdc_pkg::OSR_SEL_MAX - int'(cur_osr)));
	assign ref_tick = (st_q != sdc_pkg::SDC_IDLE) && (ref_cnt_q == ref_div_q);
	// low-power reference is eighth of 4 MHz
	assign settle_tick = ref_tick && (!lp_q || lp_cnt_q == sdc_pkg::LP_REF_LAST);
	// modulator rate is quarter of reference
	assign os_tick = settle_tick && (os_cnt_q == sdc_pkg::OS_PER_REF_LAST);
	assign dec_tick = os_tick && (dec_cnt_q == osr_last) && (st_q == sdc_pkg::SDC_CONV);

	// Divider next values
	always_comb begin
		ref_cnt_d = ref_tick ? 4'h0 : ref_cnt_q + 4'h1;
		lp_cnt_d = ref_tick ? lp_cnt_q + 3'h1 : lp_cnt_q;
		os_cnt_d = settle_tick ? os_cnt_q + 2'h1 : os_cnt_q;
		dec_cnt_d = dec_cnt_q;
		if (os_tick) begin
			dec_cnt_d = dec_tick ? 11'h000 : dec_cnt_q + 11'h001;
		end
		// conversion opens a whole modulator period
		if (filt_clr) begin
			dec_cnt_d = 11'h000;
			os_cnt_d = 2'h0;
		end
		if (st_q == sdc_pkg::SDC_IDLE) begin
			ref_cnt_d = 4'h0;
			lp_cnt_d = 3'h0;
			os_cnt_d = 2'h0;
			dec_cnt_d = 11'h000;
		end
	end

	// Divider flops
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ref_cnt_q <= 4'h0;
			lp_cnt_q <= 3'h0;
			os_cnt_q <= 2'h0;
			dec_cnt_q <= 11'h000;
		end else begin
			ref_cnt_q <= ref_cnt_d;
			lp_cnt_q <= lp_cnt_d;
			os_cnt_q <= os_cnt_d;
			dec_cnt_q <= dec_cnt_d;
		end
	end

	// ****************************************************************
	// Scan sequencer
	// ****************************************************************
	assign nxt_ch = next_scan(ch_q, scan_q);
	assign filt_clr = (st_q == sdc_pkg::SDC_SETTLE) && settle_tick && (cnt_q == cnt_last(lp_q));

	// Settling length in reference ticks for the mode
	function automatic logic [9:0] cnt_last(input logic lp);
		return lp ? sdc_pkg::SETTLE_LP_TICKS - 10'h001 : sdc_pkg::SETTLE_NORM_TICKS - 10'h001;
	endfunction

	// Sequencer next state
	always_comb begin
		st_d = st_q;
		ch_d = ch_q;
		cnt_d = cnt_q;
		outs_d = outs_q;
		pub_d = publish;
		pub_ch_d = publish ? ch_q : pub_ch_q;
		unique case (st_q)
			sdc_pkg::SDC_IDLE: begin
				cnt_d = 10'h000;
				if (start_q && |scan_q) begin
					ch_d = next_scan(3'(NCH - 1), scan_q);
					st_d = sdc_pkg::SDC_SYNC;
				end
			end
			sdc_pkg::SDC_SYNC: begin
				if (settle_tick) begin
					cnt_d = cnt_q + 10'h001;
					if (cnt_q == sdc_pkg::SYNC_REF_TICKS - 10'h001) begin
						cnt_d = 10'h000;
						st_d = sdc_pkg::SDC_SETTLE;
					end
				end
			end
			sdc_pkg::SDC_SETTLE: begin
				if (settle_tick) begin
					cnt_d = cnt_q + 10'h001;
				end
				if (filt_clr) begin
					cnt_d = 10'h000;
					outs_d = 2'h0;
					st_d = sdc_pkg::SDC_CONV;
				end
			end
			sdc_pkg::SDC_CONV: begin
				if (flt_valid && outs_q != sdc_pkg::SETTLE_OUT_LAST) begin
					outs_d = outs_q + 2'h1;
				end
				if (publish && nxt_ch != ch_q) begin
					ch_d = nxt_ch;
					st_d = sdc_pkg::SDC_SETTLE;
				end
			end
		endcase
		if (!start_q) begin
			st_d = sdc_pkg::SDC_IDLE;
		end
		route_p_d = !(se_q[ch_d] && neg_q[ch_d]);
		route_n_d = !(se_q[ch_d] && !neg_q[ch_d]);
	end

	// Sequencer flops
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= sdc_pkg::SDC_IDLE;
			ch_q <= 3'h0;
			cnt_q <= 10'h000;
			outs_q <= 2'h0;
			pub_q <= 1'b0;
			pub_ch_q <= 3'h0;
			route_p_q <= 1'b1;
			route_n_q <= 1'b1;
		end else begin
			st_q <= st_d;
			ch_q <= ch_d;
			cnt_q <= cnt_d;
			outs_q <= outs_d;
			pub_q <= pub_d;
			pub_ch_q <= pub_ch_d;
			route_p_q <= route_p_d;
			route_n_q <= route_n_d;
		end
	end

	assign mod_enable = (st_q != sdc_pkg::SDC_IDLE);
	assign low_power = lp_q;
	assign mux_channel = ch_q;
	assign noninv_from_mux = route_p_q;
	assign inv_from_mux = route_n_q;

	// ****************************************************************
	// Decimation filter
	// ****************************************************************
	// filter paced only by divided ticks
	sdc_sinc3 u_sinc3 (
		.clock(clock),
		.arst_n(arst_n),
		.clr(filt_clr),
		.os_tick(os_tick),
		.bit_in(mod_bit),
		.dec_tick(dec_tick),
		.shift(flt_shift),
		.out_valid(flt_valid),
		.out_data(flt_data)
	);

endmodule
`default_nettype wire

// >>> sdc_conv_ctrl_props.sv
`default_nettype none
module sdc_conv_ctrl_props (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic mod_enable,
	input wire logic low_power,
	input wire logic [2:0] mux_channel,
	input wire logic noninv_from_mux,
	input wire logic inv_from_mux,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// Tracking
	// ********
	logic wr_q;
	logic wr_d;
	logic [7:0] adr_q;
	logic [7:0] adr_d;
	logic [16:0] run_q;
	logic [16:0] run_d;
	logic wr_ctrl;

	// Next write phase and run length
	always_comb begin
		wr_d = hsel && htrans[1] && hready && hwrite;
		adr_d = haddr[7:0];
		run_d = mod_enable ? run_q + 17'h00001 : 17'h00000;
	end

	// Register tracking state
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= 1'b0;
			adr_q <= 8'h00;
			run_q <= 17'h00000;
		end else begin
			wr_q <= wr_d;
			adr_q <= adr_d;
			run_q <= run_d;
		end
	end

	// Control word in its data phase
	assign wr_ctrl = wr_q && (adr_q == sdc_pkg::CTRL_OFS);

	default clocking @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	// ********
	// Checks
	// ********
	a_route_has_mux: assert property (noninv_from_mux || inv_from_mux)
		else $error("Both amplifier inputs on bias");
	a_route_steady: assert property (mod_enable && $past(mod_enable, 3) && mux_channel == $past(mux_channel, 3)
		|-> $stable({noninv_from_mux, inv_from_mux})) else $error("Route moved during a run");
	a_channel_range: assert property (mux_channel < 3'(sdc_pkg::NCH))
		else $error("Channel out of range");
	a_lp_from_write: assert property ($changed(low_power) |-> $past(wr_ctrl)
		&& low_power == $past(hwdata[sdc_pkg::CTRL_LP_BIT])) else $error("Low power without write");
	a_stop_idles: assert property (wr_ctrl && !hwdata[sdc_pkg::CTRL_START_BIT] |-> ##[1:3] !mod_enable)
		else $error("Stop did not idle");
	a_start_by_write: assert property ($rose(mod_enable) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
		else $error("Run began without start");
	a_irq_cause: assert property ($rose(irq) |-> $past(mod_enable) || $past(wr_q))
		else $error("Interrupt rose without cause");
	a_irq_drop: assert property ($fell(irq) |-> $past(wr_q))
		else $error("Interrupt fell without write");
	a_settle_floor: assert property ($rose(irq) && !$past(wr_q) |-> run_q >= 17'h0050A)
		else $error("Sample before settling");

	c_irq: cover property ($rose(irq));
	c_switch: cover property (mod_enable && $changed(mux_channel));
	c_low_power: cover property (mod_enable && low_power);
endmodule

bind sdc_conv_ctrl sdc_conv_ctrl_props props (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .mod_enable(mod_enable),
	.low_power(low_power), .mux_channel(mux_channel), .noninv_from_mux(noninv_from_mux),
	.inv_from_mux(inv_from_mux), .irq(irq));
`default_nettype wire

// >>> sdc_conv_ctrl_test.sv
`default_nettype none
module sdc_conv_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, arst_n, hsel, hwrite, hready, hreadyout, hresp, mod_bit, mod_enable, low_power, irq;
	logic noninv_from_mux, inv_from_mux;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize, mux_channel;
	logic [4:0] level;
	int fail_count, comparisons, cyc, t0, t1;

	// Bus ready comes from the one slave
	assign hready = hreadyout;

	sdc_conv_ctrl uut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .mod_bit(mod_bit), .mod_enable(mod_enable), .low_power(low_power),
		.mux_channel(mux_channel), .noninv_from_mux(noninv_from_mux), .inv_from_mux(inv_from_mux), .irq(irq));
	sdc_front_model front (.clock(clock), .arst_n(arst_n), .mod_enable(mod_enable), .mux_channel(mux_channel),
		.noninv_from_mux(noninv_from_mux), .inv_from_mux(inv_from_mux), .level(level), .mod_bit(mod_bit));

	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Cycle count and hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rng(input string n, input int lo, input int hi, input int v);
		comparisons++;
		if (v < lo || v > hi) begin
			fail_count++;
			$display("Error %s expected %0d to %0d seen %0d", n, lo, hi, v);
		end
	endtask

	// One single word transfer
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		rv = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(a, 1'b0, 32'h00000000);
		chk(n, e, rv);
	endtask

	task automatic wirq();
		do @(posedge clock); while (irq !== 1'b1);
		t1 = cyc;
	endtask

	// Start channel 0 and time its first sample
	task automatic first(input int s, input logic lp, input logic [31:0] cfg);
		int m;
		int e;
		m = lp ? 8 : 1;
		e = m * (525 + 12 * (64 << s));
		bus(sdc_pkg::INT_CLR_OFS, 1'b1, 32'h0000001F);
		bus(8'h20, 1'b1, cfg);
		bus(sdc_pkg::CTRL_OFS, 1'b1, {30'h00000000, lp, 1'b1});
		t0 = cyc;
		wirq();
		rng("first sample delay", e, e + 4 + 8 * m, t1 - t0);
	endtask

	// Main sequence
	initial begin
		{arst_n, hsel, haddr, htrans, hwrite, hwdata, fail_count, comparisons, cyc} = '0;
		hsize = 3'h2;
		level = 5'h03;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		chk("idle enable", 32'h00000000, 32'(mod_enable));
		rd(sdc_pkg::CTRL_OFS, 32'h00000040, "control reset");
		rd(8'h20, 32'h00000002, "ratio reset");
		rd(8'h3C, 32'h00000000, "unmapped");
		bus(sdc_pkg::INT_EN_OFS, 1'b1, 32'h0000001F);
		// Positive single-ended at ratio 256
		first(2, 1'b0, 32'h0000002A);
		chk("route plus", 32'h00000002, {30'h00000000, noninv_from_mux, inv_from_mux});
		rd(8'h40, 32'h00800000, "data ch0");
		for (int i = 0; i < 2; i++) begin
			t0 = t1;
			bus(sdc_pkg::INT_CLR_OFS, 1'b1, 32'h00000001);
			wirq();
			rng("sample spacing", 1024, 1024, t1 - t0);
		end
		// Scan onto negative single-ended channel
		bus(sdc_pkg::CTRL_OFS, 1'b1, 32'h00000000);
		repeat (2) @(posedge clock);
		chk("stopped", 32'h00000000, 32'(mod_enable));
		bus(8'h24, 1'b1, 32'h0000003A);
		first(2, 1'b0, 32'h0000002A);
		chk("route minus", 32'h00000001, {30'h00000000, noninv_from_mux, inv_from_mux});
		chk("channel", 32'h00000001, 32'(mux_channel));
		t0 = t1;
		bus(sdc_pkg::INT_CLR_OFS, 1'b1, 32'h00000001);
		wirq();
		rng("switch delay", 3587, 3589, t1 - t0);
		rd(sdc_pkg::INT_STAT_OFS, 32'h00000002, "status bits");
		rd(8'h44, 32'h00000000, "data ch1");
		bus(sdc_pkg::CTRL_OFS, 1'b1, 32'h00000000);
		bus(8'h24, 1'b1, 32'h00000000);
		// Ratio codes 0 to 5, differential
		for (int s = 0; s < 6; s++) begin
			first(s, 1'b0, 32'h00000020 | 32'(s));
			chk("route diff", 32'h00000003, {30'h00000000, noninv_from_mux, inv_from_mux});
			rd(8'h40, 32'h00800000, "scaled data");
			bus(sdc_pkg::CTRL_OFS, 1'b1, 32'h00000000);
		end
		// Low-power rates
		first(0, 1'b1, 32'h00000020);
		chk("low power", 32'h00000001, 32'(low_power));
		t0 = t1;
		bus(sdc_pkg::INT_CLR_OFS, 1'b1, 32'h00000001);
		wirq();
		rng("low power spacing", 2048, 2048, t1 - t0);
		// Mask, read-only write and clear
		bus(sdc_pkg::CTRL_OFS, 1'b1, 32'h00000000);
		bus(sdc_pkg::INT_EN_OFS, 1'b1, 32'h00000000);
		@(posedge clock);
		chk("masked irq", 32'h00000000, 32'(irq));
		bus(sdc_pkg::INT_STAT_OFS, 1'b1, 32'h00000000);
		rd(sdc_pkg::INT_STAT_OFS, 32'h00000001, "sticky status");
		bus(sdc_pkg::INT_EN_OFS, 1'b1, 32'h00000001);
		@(posedge clock);
		chk("unmasked irq", 32'h00000001, 32'(irq));
		bus(sdc_pkg::INT_CLR_OFS, 1'b1, 32'h00000001);
		@(posedge clock);
		chk("cleared irq", 32'h00000000, 32'(irq));
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> sdc_front_model.sv
`default_nettype none
module sdc_front_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic mod_enable,
	input wire logic [2:0] mux_channel,
	input wire logic noninv_from_mux,
	input wire logic inv_from_mux,
	input wire logic [4:0] level,
	output logic mod_bit
);
	timeunit 1ns;
	timeprecision 1ns;
	logic idle_q;

	// Idle pattern flips each cycle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			idle_q <= 1'b0;
		end else begin
			idle_q <= !idle_q;
		end
	end

	// input side polarity
	// Signal on inverting side only flips the stream
	always_comb begin
		if (!mod_enable) begin
			mod_bit = idle_q;
		end else begin
			mod_bit = level[mux_channel] ^ (inv_from_mux && !noninv_from_mux);
		end
	end
endmodule
`default_nettype wire

// >>> sdc_pkg.sv
`default_nettype none
package sdc_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NCH = 5;
	localparam int ACC_W = 34;
	localparam int OUT_W = 24;
	localparam int OSR_SEL_MAX = 5;

	// ****************************************************************
	// Clock rates and settling times
	// ****************************************************************
	localparam int CLK_KHZ = 20000;
	localparam int REF_NORM_KHZ = 4000;
	localparam int REF_LP_KHZ = 500;
	localparam int SETTLE_NORM_NS = 129000;
	localparam int SETTLE_LP_NS = 1032000;
	localparam logic [3:0] REF_DIV_RST = 4'((CLK_KHZ / REF_NORM_KHZ) - 1);
	localparam logic [2:0] LP_REF_LAST = 3'((REF_NORM_KHZ / REF_LP_KHZ) - 1);
	localparam logic [1:0] OS_PER_REF_LAST = 2'h3;
	localparam logic [9:0] SETTLE_NORM_TICKS = 10'((SETTLE_NORM_NS / 1000) * (REF_NORM_KHZ / 1000));
	localparam logic [9:0] SETTLE_LP_TICKS = 10'((SETTLE_LP_NS / 1000) * REF_LP_KHZ / 1000);
	localparam logic [9:0] SYNC_REF_TICKS = 10'h009;
	localparam logic [1:0] SETTLE_OUT_LAST = 2'h2;

	// ****************************************************************
	// Register map, byte addresses
	// ****************************************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] INT_STAT_OFS = 8'h08;
	localparam logic [7:0] INT_CLR_OFS = 8'h0C;
	localparam logic [7:0] INT_EN_OFS = 8'h10;
	localparam logic [2:0] CHCFG_PAGE = 3'h1;
	localparam logic [2:0] DATA_PAGE = 3'h2;

	// Control field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_LP_BIT = 1;
	localparam int CTRL_DIV_LSB = 4;
	// Channel config field positions
	localparam int CFG_OSR_LSB = 0;
	localparam int CFG_SE_BIT = 3;
	localparam int CFG_NEG_BIT = 4;
	localparam int CFG_SCAN_BIT = 5;
	localparam logic [2:0] CFG_OSR_RST = 3'h2;

	// Sequencer states, Gray along the usual path
	typedef enum logic [1:0] {
		SDC_IDLE = 2'b00,
		SDC_SYNC = 2'b01,
		SDC_SETTLE = 2'b11,
		SDC_CONV = 2'b10
	} sdc_state_t;

endpackage
`default_nettype wire

// >>> sdc_sinc3.sv
`default_nettype none
module sdc_sinc3 #(
	parameter int ACC_W = sdc_pkg::ACC_W,
	parameter int OUT_W = sdc_pkg::OUT_W
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clr,
	input wire logic os_tick,
	input wire logic bit_in,
	input wire logic dec_tick,
	input wire logic [3:0] shift,
	output logic out_valid,
	output logic [OUT_W-1:0] out_data
);

	// ****************************************************************
	// Integrators at modulator rate, combs at output rate
	// ****************************************************************
	logic [ACC_W-1:0] int_q [3];
	logic [ACC_W-1:0] int_d [3];
	logic [ACC_W-1:0] dly_q [3];
	logic [ACC_W-1:0] dly_d [3];
	logic [ACC_W-1:0] diff [3];
	logic [ACC_W-1:0] scaled;
	logic valid_d;
	logic valid_q;
	logic [OUT_W-1:0] data_d;
	logic [OUT_W-1:0] data_q;

	// Next values of the cascades
	always_comb begin
		int_d = int_q;
		dly_d = dly_q;
		valid_d = 1'b0;
		data_d = data_q;
		if (os_tick) begin
			int_d[0] = int_q[0] + ACC_W'(bit_in);
			int_d[1] = int_q[1] + int_q[0];
			int_d[2] = int_q[2] + int_q[1];
		end
		// Combs see this tick's sample, so full scale is exact
		diff[0] = int_d[2] - dly_q[0];
		diff[1] = diff[0] - dly_q[1];
		diff[2] = diff[1] - dly_q[2];
		scaled = diff[2] << shift;
		if (dec_tick) begin
			dly_d[0] = int_d[2];
			dly_d[1] = diff[0];
			dly_d[2] = diff[1];
			data_d = scaled[ACC_W-1 -: OUT_W];
			valid_d = 1'b1;
		end
		if (clr) begin
			int_d = '{default: '0};
			dly_d = '{default: '0};
			valid_d = 1'b0;
		end
	end

	// State registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			int_q <= '{default: '0};
			dly_q <= '{default: '0};
			valid_q <= 1'b0;
			data_q <= '0;
		end else begin
			int_q <= int_d;
			dly_q <= dly_d;
			valid_q <= valid_d;
			data_q <= data_d;
		end
	end

	assign out_valid = valid_q;
	assign out_data = data_q;

endmodule
`default_nettype wire
